// ===== acvt_top.sv
// Constant velocity move task controller with APB register access.
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module acvt_top #(
    parameter int PROG_CYCLE_CLKS = acvt_pkg::ACVT_PROG_CYCLE_CLKS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic axis_enabled,
    input wire logic signed [31:0] axis_actual_velocity,
    input wire logic other_task_start,
    input wire logic other_task_is_homing,
    input wire logic [2:0] other_homing_mode,
    output logic signed [31:0] axis_velocity_cmd,
    output logic axis_drive_en,
    output logic abort_others,
    output logic velocity_task_active,
    output logic steady_rate_flag,
    output logic busy,
    output logic at_target_speed,
    output logic task_aborted,
    output logic task_error,
    output logic [15:0] fault_code,
    output logic [15:0] fault_detail
);
    import acvt_pkg::*;

    // =====================================================================
    // Helper functions
    // =====================================================================
    function automatic logic [31:0] mag(input logic signed [31:0] v);
        mag = v[31] ? 32'(-v) : 32'(v);
    endfunction

    // Moves v one step of at most acc (speeding up) or dec (slowing down).
    function automatic logic signed [31:0] step_toward(
        input logic signed [31:0] v,
        input logic signed [31:0] t,
        input logic [31:0] acc,
        input logic [31:0] dec
    );
        logic [31:0] lim;
        logic signed [32:0] diff;
        lim = 32'h0;
        diff = 33'sh0;
        if ((v == 32'sh0) || (v[31] == t[31] && mag(t) > mag(v))) begin
            lim = acc;
        end else begin
            lim = dec;
        end
        diff = 33'(t) - 33'(v);
        if (diff[32]) begin
            if (33'(-diff) <= 33'({1'b0, lim})) begin
                step_toward = t;
            end else begin
                step_toward = 32'(v - $signed(lim));
            end
        end else if (diff <= 33'({1'b0, lim})) begin
            step_toward = t;
        end else begin
            step_toward = 32'(v + $signed(lim));
        end
    endfunction

    // =====================================================================
    // APB register file
    // =====================================================================
    logic exec_r;
    logic hold_r;
    logic signed [31:0] vel_r;
    logic [15:0] dir_r;
    logic [31:0] vmin_r;
    logic [31:0] vmax_r;
    logic [31:0] acc_r;
    logic [31:0] dec_r;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [7:0] ofs;

    assign ofs = paddr[7:0];
    assign addr_ok = (paddr[31:8] == 24'h0) && (paddr[1:0] == 2'h0) &&
                     (ofs <= ACVT_ACT_OFS);
    assign wr_en = psel && penable && pwrite && addr_ok;
    assign rd_en = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exec_r <= 1'b0;
            hold_r <= 1'b0;
            vel_r <= ACVT_VEL_RST;
            dir_r <= ACVT_DIR_SIGN;
            vmin_r <= ACVT_VMIN_RST;
            vmax_r <= ACVT_VMAX_RST;
            acc_r <= ACVT_ACC_RST;
            dec_r <= ACVT_DEC_RST;
        end else if (wr_en) begin
            case (ofs)
                ACVT_CTRL_OFS: begin
                    exec_r <= pwdata[ACVT_CTRL_EXEC_BIT];
                    hold_r <= pwdata[ACVT_CTRL_HOLD_BIT];
                end
                ACVT_VEL_OFS: vel_r <= pwdata;
                ACVT_DIR_OFS: dir_r <= pwdata[15:0];
                ACVT_VMIN_OFS: vmin_r <= pwdata;
                ACVT_VMAX_OFS: vmax_r <= pwdata;
                ACVT_ACC_OFS: acc_r <= pwdata;
                ACVT_DEC_OFS: dec_r <= pwdata;
                default: begin
                end
            endcase
        end
    end

    logic [31:0] rd_nxt;
    always_comb begin
        rd_nxt = 32'h0;
        case (ofs)
            ACVT_CTRL_OFS: begin
                rd_nxt[ACVT_CTRL_EXEC_BIT] = exec_r;
                rd_nxt[ACVT_CTRL_HOLD_BIT] = hold_r;
            end
            ACVT_VEL_OFS: rd_nxt = vel_r;
            ACVT_DIR_OFS: rd_nxt = {16'h0, dir_r};
            ACVT_VMIN_OFS: rd_nxt = vmin_r;
            ACVT_VMAX_OFS: rd_nxt = vmax_r;
            ACVT_ACC_OFS: rd_nxt = acc_r;
            ACVT_DEC_OFS: rd_nxt = dec_r;
            ACVT_STAT_OFS: begin
                rd_nxt[ACVT_ST_AT_SPEED] = at_target_speed;
                rd_nxt[ACVT_ST_BUSY] = busy;
                rd_nxt[ACVT_ST_ABORTED] = task_aborted;
                rd_nxt[ACVT_ST_ERROR] = task_error;
                rd_nxt[ACVT_ST_VTA] = velocity_task_active;
                rd_nxt[ACVT_ST_STEADY] = steady_rate_flag;
            end
            ACVT_FAULT_OFS: rd_nxt = {fault_detail, fault_code};
            ACVT_ACT_OFS: rd_nxt = axis_velocity_cmd;
            default: rd_nxt = 32'h0;
        endcase
    end

    // Read data is captured in the setup phase and stands in the access phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (rd_en) begin
            prdata <= rd_nxt;
        end
    end

    // =====================================================================
    // Start detection and parameter check
    // =====================================================================
    logic exec_d_r;
    logic start;
    logic [31:0] vmag;
    logic vel_ok;
    logic dir_ok;
    logic signed [31:0] tgt_nxt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exec_d_r <= 1'b0;
        end else begin
            exec_d_r <= exec_r;
        end
    end

    assign start = exec_r && !exec_d_r; // see [RQ2]
    assign vmag = mag(vel_r);
    assign vel_ok = (vmag == 32'h0) ||
                    (vmag >= vmin_r && vmag <= vmax_r); // see [RQ3] [RQ22]
    assign dir_ok = (dir_r <= ACVT_DIR_NEG); // see [RQ22]

    always_comb begin
        if (hold_r) begin
            tgt_nxt = axis_actual_velocity; // see [RQ6]
        end else if (dir_r == ACVT_DIR_POS) begin
            tgt_nxt = vmag; // see [RQ4] [RQ5]
        end else if (dir_r == ACVT_DIR_NEG) begin
            tgt_nxt = 32'(-$signed(vmag)); // see [RQ4]
        end else begin
            tgt_nxt = vel_r; // see [RQ4]
        end
    end

    logic param_bad;
    logic start_ok;
    logic ext_abort;
    assign param_bad = !hold_r && (!vel_ok || !dir_ok);
    assign start_ok = start && !param_bad && axis_enabled; // see [RQ1]
    assign ext_abort = other_task_start && (!other_task_is_homing ||
                       other_homing_mode == ACVT_HOME_ABORT_MODE); // see [RQ12]

    // =====================================================================
    // Program cycle tick
    // =====================================================================
    logic [31:0] tick_cnt_r;
    logic tick;
    assign tick = (tick_cnt_r == 32'(PROG_CYCLE_CLKS - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_r <= 32'h0;
        end else if (tick) begin
            tick_cnt_r <= 32'h0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h1;
        end
    end

    // =====================================================================
    // Task sequencer
    // =====================================================================
    acvt_state_e state_r;
    logic signed [31:0] tgt_r;
    logic zero_r;
    logic at_speed_now;
    logic stop_seen_r;
    assign at_speed_now = (axis_velocity_cmd == tgt_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ACVT_IDLE;
            tgt_r <= 32'sh0;
            zero_r <= 1'b0;
            stop_seen_r <= 1'b0;
        end else if (start_ok) begin
            state_r <= ACVT_RAMP;
            tgt_r <= tgt_nxt;
            zero_r <= (tgt_nxt == 32'sh0); // see [RQ14]
            stop_seen_r <= 1'b0;
        end else if (ext_abort && state_r != ACVT_IDLE) begin
            state_r <= ACVT_IDLE; // see [RQ10]
        end else begin
            case (state_r)
                ACVT_RAMP: begin
                    if (at_speed_now) begin
                        state_r <= zero_r ? ACVT_STOPPED : ACVT_CRUISE;
                    end
                end
                ACVT_CRUISE: state_r <= ACVT_CRUISE; // see [RQ21]
                ACVT_STOPPED: begin
                    // Standstill flag shows until at least the next program cycle tick.
                    if (tick) begin
                        stop_seen_r <= 1'b1; // see [RQ15]
                    end
                    if (stop_seen_r && !exec_r) begin
                        state_r <= ACVT_IDLE; // see [RQ16] [RQ17]
                    end
                end
                default: state_r <= ACVT_IDLE;
            endcase
        end
    end

    assign busy = (state_r == ACVT_RAMP) || (state_r == ACVT_CRUISE) ||
                  (state_r == ACVT_STOPPED); // see [RQ9] [RQ16] [RQ17]
    assign at_target_speed = (state_r == ACVT_CRUISE) ||
                  (state_r == ACVT_STOPPED); // see [RQ7] [RQ8] [RQ15]
    assign axis_drive_en = busy;
    assign abort_others = start_ok; // see [RQ13] [RQ14]

    // =====================================================================
    // Velocity profile
    // =====================================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            axis_velocity_cmd <= 32'sh0;
        end else if (start_ok) begin
            axis_velocity_cmd <= axis_actual_velocity; // see [RQ6]
        end else if (state_r == ACVT_RAMP && tick) begin
            axis_velocity_cmd <= step_toward(axis_velocity_cmd, tgt_r,
                                             acc_r, dec_r); // see [RQ21]
        end
    end

    // =====================================================================
    // Result flags, fault words and axis status bits
    // =====================================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            task_aborted <= 1'b0;
        end else if (ext_abort && busy) begin
            task_aborted <= 1'b1; // see [RQ10]
        end else if (start) begin
            task_aborted <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            task_error <= 1'b0;
            fault_code <= ACVT_FC_NONE;
            fault_detail <= ACVT_FD_NONE;
        end else if (start) begin
            if (!axis_enabled) begin
                task_error <= 1'b1; // see [RQ11]
                fault_code <= ACVT_FC_DISABLED;
                fault_detail <= ACVT_FD_AXIS;
            end else if (param_bad) begin
                task_error <= 1'b1; // see [RQ11] [RQ22]
                fault_code <= ACVT_FC_PARAM;
                fault_detail <= vel_ok ? ACVT_FD_DIRECTION : ACVT_FD_VELOCITY;
            end else begin
                task_error <= 1'b0;
                fault_code <= ACVT_FC_NONE;
                fault_detail <= ACVT_FD_NONE;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            velocity_task_active <= 1'b0;
            steady_rate_flag <= 1'b0;
        end else if (start_ok) begin
            velocity_task_active <= 1'b1; // see [RQ18]
            steady_rate_flag <= 1'b0;
        end else if (other_task_start) begin
            velocity_task_active <= 1'b0; // see [RQ20]
            steady_rate_flag <= 1'b0;
        end else if (state_r == ACVT_RAMP && at_speed_now && zero_r) begin
            steady_rate_flag <= 1'b1; // see [RQ19]
        end
    end
endmodule
`default_nettype wire

// ===== acvt_pkg.sv
// Package with register map, field layout, fault codes and timing constants.
// Operation
// [RQ1] Program enables axis before starting a task
// [RQ2] New task starts only on execute rising edge
// [RQ3] Velocity magnitude within start/stop..max, or zero
// [RQ4] Direction 0 sign, 1 positive, 2 negative
// [RQ5] Hold off: use supplied velocity and direction
// [RQ6] Hold on: keep velocity present at start
// [RQ7] Hold off: flag target speed when reached
// [RQ8] Hold on: flag target speed at start velocity
// [RQ9] Busy stays high while task executes
// [RQ10] Aborted flag when another task interrupts
// [RQ11] Error raises fault code and detail words
// [RQ12] Homing mode 3 and all moves abort task
// [RQ13] New task aborts all other active motion tasks
// [RQ14] Zero velocity acts as stop with deceleration
// [RQ15] Zero velocity: target flag at standstill, cycle
// [RQ16] Zero velocity: busy falls with target flag
// [RQ17] Execute high latches target flag and busy
// [RQ18] Start sets velocity task active bit
// [RQ19] Standstill sets steady rate bit
// [RQ20] Later motion task start updates both bits
// [RQ21] Ramp with accel/decel, then hold constant
// [RQ22] Bad velocity or direction raises error
package acvt_pkg;
    localparam logic [7:0] ACVT_CTRL_OFS = 8'h00;
    localparam logic [7:0] ACVT_VEL_OFS = 8'h04;
    localparam logic [7:0] ACVT_DIR_OFS = 8'h08;
    localparam logic [7:0] ACVT_VMIN_OFS = 8'h0C;
    localparam logic [7:0] ACVT_VMAX_OFS = 8'h10;
    localparam logic [7:0] ACVT_ACC_OFS = 8'h14;
    localparam logic [7:0] ACVT_DEC_OFS = 8'h18;
    localparam logic [7:0] ACVT_STAT_OFS = 8'h1C;
    localparam logic [7:0] ACVT_FAULT_OFS = 8'h20;
    localparam logic [7:0] ACVT_ACT_OFS = 8'h24;

    localparam int ACVT_CTRL_EXEC_BIT = 0;
    localparam int ACVT_CTRL_HOLD_BIT = 1;

    localparam int ACVT_ST_AT_SPEED = 0;
    localparam int ACVT_ST_BUSY = 1;
    localparam int ACVT_ST_ABORTED = 2;
    localparam int ACVT_ST_ERROR = 3;
    localparam int ACVT_ST_VTA = 4;
    localparam int ACVT_ST_STEADY = 5;

    localparam logic [31:0] ACVT_VEL_RST = 32'h0000000A;
    localparam logic [31:0] ACVT_VMIN_RST = 32'h00000001;
    localparam logic [31:0] ACVT_VMAX_RST = 32'h00000064;
    localparam logic [31:0] ACVT_ACC_RST = 32'h0000000A;
    localparam logic [31:0] ACVT_DEC_RST = 32'h0000000A;

    localparam logic [15:0] ACVT_DIR_SIGN = 16'h0000;
    localparam logic [15:0] ACVT_DIR_POS = 16'h0001;
    localparam logic [15:0] ACVT_DIR_NEG = 16'h0002;
    localparam logic [2:0] ACVT_HOME_ABORT_MODE = 3'h3;

    localparam logic [15:0] ACVT_FC_NONE = 16'h0000;
    localparam logic [15:0] ACVT_FC_PARAM = 16'h8001;
    localparam logic [15:0] ACVT_FC_DISABLED = 16'h8002;
    localparam logic [15:0] ACVT_FD_NONE = 16'h0000;
    localparam logic [15:0] ACVT_FD_VELOCITY = 16'h0001;
    localparam logic [15:0] ACVT_FD_DIRECTION = 16'h0002;
    localparam logic [15:0] ACVT_FD_AXIS = 16'h0003;

    localparam int ACVT_CLK_HZ = 25000000;
    localparam int ACVT_PROG_CYCLE_US = 1000;
    localparam int ACVT_PROG_CYCLE_CLKS =
        (ACVT_CLK_HZ / 1000000) * ACVT_PROG_CYCLE_US;

    typedef enum logic [1:0] {
        ACVT_IDLE,
        ACVT_RAMP,
        ACVT_CRUISE,
        ACVT_STOPPED
    } acvt_state_e;
endpackage

// ===== acvt_axis_model.sv
// Behavioural axis object that follows the velocity command.
`timescale 1ns/1ps
`default_nettype none
module acvt_axis_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic en_req,
    input wire logic slow,
    input wire logic signed [31:0] cmd,
    output logic axis_enabled,
    output logic signed [31:0] vel
);
    logic [1:0] div_r;
    // The slow mode follows the command only every fourth clock.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 2'h0;
            vel <= 32'h00000000;
            axis_enabled <= 1'b0;
        end else begin
            div_r <= div_r + 2'h1;
            axis_enabled <= en_req;
            if (!slow || div_r == 2'h0) begin
                vel <= cmd;
            end
        end
    end
endmodule
`default_nettype wire

// ===== acvt_sva.sv
// Checker of the task controller outputs against their causes.
`timescale 1ns/1ps
`default_nettype none
module acvt_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic other_task_start,
    input wire logic other_task_is_homing,
    input wire logic [2:0] other_homing_mode,
    input wire logic signed [31:0] axis_velocity_cmd,
    input wire logic axis_drive_en,
    input wire logic abort_others,
    input wire logic velocity_task_active,
    input wire logic steady_rate_flag,
    input wire logic busy,
    input wire logic at_target_speed,
    input wire logic task_aborted,
    input wire logic task_error,
    input wire logic [15:0] fault_code
);
    logic kill;
    logic home_other;
    assign home_other = other_task_start && other_task_is_homing;
    assign kill = other_task_start &&
        (!other_task_is_homing || other_homing_mode == 3'h3);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================================
    // Properties
    property p_drive; axis_drive_en == busy; endproperty
    property p_kill;
        busy && kill && !abort_others |=> task_aborted && !busy;
    endproperty
    property p_keep;
        busy && home_other && other_homing_mode != 3'h3 && !abort_others
            |=> !task_aborted;
    endproperty
    property p_start; abort_others |=> busy && velocity_task_active;
    endproperty
    property p_pulse; abort_others |=> !abort_others; endproperty
    property p_steady;
        $rose(steady_rate_flag) |-> axis_velocity_cmd == 32'h00000000;
    endproperty
    property p_zero;
        $fell(busy) && !task_aborted |-> $fell(at_target_speed);
    endproperty
    property p_err; task_error |-> fault_code != 16'h0000; endproperty
    property p_hold;
        at_target_speed && busy && !other_task_start && !abort_others
            |=> $stable(axis_velocity_cmd);
    endproperty
    a_drive: assert property (p_drive)
        else $error("drive enable differs from busy");
    a_kill: assert property (p_kill)
        else $error("task not aborted by other task");
    a_keep: assert property (p_keep)
        else $error("homing in other mode aborted task");
    a_start: assert property (p_start)
        else $error("start without busy or active bit");
    a_pulse: assert property (p_pulse)
        else $error("abort pulse longer than one cycle");
    a_steady: assert property (p_steady)
        else $error("steady flag without standstill");
    a_zero: assert property (p_zero)
        else $error("busy fell apart from target flag");
    a_err: assert property (p_err)
        else $error("error without fault code");
    a_hold: assert property (p_hold)
        else $error("command moved while at target");
    c_start: cover property (abort_others);
    c_abort: cover property (busy && kill);
    c_stop: cover property ($fell(busy) && !task_aborted);
    c_err: cover property ($rose(task_error));
endmodule
bind acvt_top acvt_sva u_sva (
    .pclk(pclk),
    .presetn(presetn),
    .other_task_start(other_task_start),
    .other_task_is_homing(other_task_is_homing),
    .other_homing_mode(other_homing_mode),
    .axis_velocity_cmd(axis_velocity_cmd),
    .axis_drive_en(axis_drive_en),
    .abort_others(abort_others),
    .velocity_task_active(velocity_task_active),
    .steady_rate_flag(steady_rate_flag),
    .busy(busy),
    .at_target_speed(at_target_speed),
    .task_aborted(task_aborted),
    .task_error(task_error),
    .fault_code(fault_code)
);
`default_nettype wire

// ===== axis_constant_velocity_task_tb.sv
// Self-checking testbench of the constant velocity task controller.
`timescale 1ns/1ps
`default_nettype none
module axis_constant_velocity_task_tb;
    import acvt_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic [31:0] paddr, pwdata, prdata, rdat;
    logic axis_enabled, en_req, slow, abort_others, busy, task_error;
    logic other_task_start, other_task_is_homing, axis_drive_en;
    logic velocity_task_active, steady_rate_flag, at_target_speed;
    logic task_aborted;
    logic [2:0] other_homing_mode;
    logic signed [31:0] axis_actual_velocity, axis_velocity_cmd;
    logic [15:0] fault_code, fault_detail;
    int error_cnt, checked, n_abort, n0;
    logic [7:0] ofs [8] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18,
        8'h1C, 8'h20};
    logic [31:0] dv [8] = '{32'h0000000A, 32'h0, 32'h1, 32'h00000064,
        32'h0000000A, 32'h0000000A, 32'h0, 32'h0};
    logic [31:0] dirv [3] = '{32'hFFFFFFEC, 32'h00000014, 32'hFFFFFFEC};
    acvt_top #(.PROG_CYCLE_CLKS(4)) u_dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .axis_enabled(axis_enabled),
        .axis_actual_velocity(axis_actual_velocity),
        .other_task_start(other_task_start),
        .other_task_is_homing(other_task_is_homing),
        .other_homing_mode(other_homing_mode),
        .axis_velocity_cmd(axis_velocity_cmd),
        .axis_drive_en(axis_drive_en), .abort_others(abort_others),
        .velocity_task_active(velocity_task_active),
        .steady_rate_flag(steady_rate_flag), .busy(busy),
        .at_target_speed(at_target_speed), .task_aborted(task_aborted),
        .task_error(task_error), .fault_code(fault_code),
        .fault_detail(fault_detail));
    acvt_axis_model u_axis (.pclk(pclk), .presetn(presetn),
        .en_req(en_req), .slow(slow), .cmd(axis_velocity_cmd),
        .axis_enabled(axis_enabled), .vel(axis_actual_velocity));
    always #20 pclk = ~pclk;
    always @(posedge pclk) if (abort_others === 1'b1) n_abort <= n_abort + 1;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic wait_at();
        repeat (2) @(posedge pclk);
        for (int i = 0; i < 2000 && at_target_speed !== 1'b1; i++)
            @(posedge pclk);
        chk(at_target_speed, 1'b1);
    endtask
    task automatic pulse(input logic h, input logic [2:0] m);
        @(posedge pclk);
        other_task_start <= 1'b1;
        other_task_is_homing <= h;
        other_homing_mode <= m;
        @(posedge pclk);
        other_task_start <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    task end_of_test;
        $display("errors=%0d checks=%0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        end_of_test();
    end
    // ==========================================================
    // Test sequence
    initial begin
        {pclk, presetn, psel, penable, pwrite, slow, other_task_start} = 0;
        {other_task_is_homing, other_homing_mode, error_cnt, checked} = 0;
        {paddr, pwdata, n_abort} = 0;
        en_req = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd(ofs[i]);
            chk(rdat, dv[i]);
        end
        rd(8'h40);
        chk(rerr, 1'b1);
        wr(8'h00, 32'h1);
        rd(8'h20);
        chk(rdat, 32'h00038002);
        chk(task_error, 1'b1);
        wr(8'h00, 32'h0);
        en_req <= 1'b1;
        wr(8'h08, 32'h3);
        wr(8'h00, 32'h1);
        rd(8'h20);
        chk(rdat, 32'h00028001);
        wr(8'h00, 32'h0);
        wr(8'h04, 32'hFFFFFFEC);
        for (int d = 0; d < 3; d++) begin
            wr(8'h08, d);
            n0 = n_abort;
            wr(8'h00, 32'h1);
            wait_at();
            chk(axis_velocity_cmd, dirv[d]);
            chk(n_abort, n0 + 1);
            wr(8'h00, 32'h1);
            chk(n_abort, n0 + 1);
            wr(8'h00, 32'h0);
        end
        wr(8'h04, 32'h000000C8);
        wr(8'h00, 32'h1);
        rd(8'h20);
        chk(rdat, 32'h00018001);
        chk(busy, 1'b1);
        slow <= 1'b1;
        wr(8'h04, 32'h00000032);
        wr(8'h00, 32'h0);
        wr(8'h00, 32'h3);
        wait_at();
        chk(axis_velocity_cmd, 32'hFFFFFFEC);
        chk(velocity_task_active, 1'b1);
        pulse(1'b1, 3'h2);
        chk(busy, 1'b1);
        chk(velocity_task_active, 1'b0);
        pulse(1'b1, 3'h3);
        chk(task_aborted, 1'b1);
        chk(busy, 1'b0);
        chk(velocity_task_active, 1'b0);
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h0);
        wr(8'h00, 32'h1);
        wait_at();
        chk(steady_rate_flag, 1'b1);
        chk(axis_velocity_cmd, 32'h0);
        repeat (20) @(posedge pclk);
        chk({at_target_speed, busy}, 2'h3);
        wr(8'h00, 32'h0);
        repeat (10) @(posedge pclk);
        chk({at_target_speed, busy}, 2'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
